// [hdl/pag_phase_acc.sv]
// Purpose: Multi-channel phase accumulating waveform address generator
// Assumes: Phase engine logic on the same clock writes the control words
// Notes:   Accumulator steps once every TICK_CYCLES clocks (10 MHz)
//
// Notes on behaviour
// (RULE1) A frequency control word written by the engine sets the output frequency.
// (RULE2) Each accumulator step adds the live increment into the summing register.
// (RULE3) The running sum is the waveform RAM address, one step per tick.
// (RULE4) A new address is produced at a fixed 10 MHz rate in every mode.
// (RULE5) The engine places new words within the interval between two steps.
// (RULE6) Frequency comes only from the increment size, never from the rate.
// (RULE7) Each channel RAM holds one period as 8192 amplitude points.
// (RULE8) Loading one channel RAM changes only that channel's waveform.
// (RULE9) A fixed frequency is one unchanging increment loaded once.
// (RULE10) A sweep loads a rising series of increments shared by all channels.
// (RULE11) Each channel has its own phase word, swept independently.
// (RULE12) A constant phase word gives that channel a fixed address offset.
// (RULE13) Control words are in RAM address units, not degrees.
// (RULE14) Increments and sum are 40 bits, the address given out is 16 bits.
// (RULE15) Two increment registers alternate, the engine loading the idle one.
// (RULE16) The sum wraps at full width; address is its top plus the offset.
// (RULE17) A control write takes effect at the next step, sum undisturbed.
`timescale 1ns/1ps
module pag_phase_acc
(
  input  wire logic                                     clk,
  input  wire logic                                     reset_n,
  input  wire pag_pkg::pag_ctrl_wr_t                    ctrlWr,
  input  wire pag_pkg::pag_wave_wr_t                    waveWr,
  output logic                                          addrStrobe,
  output logic [pag_pkg::INC_W-1:0]                     phaseSum,
  output logic [pag_pkg::NUM_CH-1:0][pag_pkg::ADDR_W-1:0] chanAddr,
  output logic [pag_pkg::NUM_CH-1:0][pag_pkg::AMP_W-1:0]  chanSample
);

  // Step timing
  logic [pag_pkg::TICK_CW-1:0] tickCnt_reg;
  logic [pag_pkg::TICK_CW-1:0] tickCnt_next;
  logic                        tick;
  logic                        addrStrobe_reg;

  // Alternating increment pair and summing register
  logic [pag_pkg::INC_W-1:0]   incA_reg;
  logic [pag_pkg::INC_W-1:0]   incA_next;
  logic [pag_pkg::INC_W-1:0]   incB_reg;
  logic [pag_pkg::INC_W-1:0]   incB_next;
  logic                        activeSel_reg;
  logic                        activeSel_next;
  logic                        pending_reg;
  logic                        pending_next;
  logic                        swapNow;
  logic                        loadTarget;
  logic [pag_pkg::INC_W-1:0]   incActive;
  logic [pag_pkg::INC_W-1:0]   incUsed;
  logic [pag_pkg::INC_W-1:0]   sum_reg;
  logic [pag_pkg::INC_W-1:0]   sum_next;
  logic [pag_pkg::ADDR_W-1:0]  sumAddr;

  // Per-channel wires
  logic [pag_pkg::NUM_CH-1:0]                     phaseWrEn;
  logic [pag_pkg::NUM_CH-1:0]                     waveWrEn;
  logic [pag_pkg::NUM_CH-1:0][pag_pkg::ADDR_W-1:0] phaseLive;

  // Free-running step divider, independent of any setting [RULE4] [RULE6]
  assign tick         = (tickCnt_reg == pag_pkg::TICK_LAST);
  assign tickCnt_next = tick ? pag_pkg::TICK_CNT_RST
                             : pag_pkg::TICK_CW'(tickCnt_reg + 1'b1);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tickCnt_reg    <= pag_pkg::TICK_CNT_RST;
      addrStrobe_reg <= 1'b0;
    end
    else
    begin
      tickCnt_reg    <= tickCnt_next;
      addrStrobe_reg <= tick;
    end
  end

  // Swap on a step when a new word waits; load the idle register [RULE15]
  assign swapNow        = tick & pending_reg;
  assign activeSel_next = swapNow ? ~activeSel_reg : activeSel_reg;
  assign loadTarget     = ~activeSel_next;
  // New word lands in the register left idle after this cycle's swap [RULE1] [RULE10]
  assign incA_next = (ctrlWr.freqWr && !loadTarget) ? ctrlWr.data : incA_reg;
  assign incB_next = (ctrlWr.freqWr && loadTarget) ? ctrlWr.data : incB_reg;
  // A write in a step cycle stays pending; set wins over clear [RULE17]
  assign pending_next = ctrlWr.freqWr | (pending_reg & ~tick);

  // Live increment before any swap, and the one actually added at this step after any swap [RULE2]
  assign incActive = activeSel_reg ? incB_reg : incA_reg;
  assign incUsed   = activeSel_next ? incB_reg : incA_reg;
  // Full-width wrap of the summing register [RULE14] [RULE16]
  assign sum_next  = tick ? pag_pkg::INC_W'(sum_reg + incUsed) : sum_reg;
  // Address is the top 16 bits of the sum [RULE3] [RULE16]
  assign sumAddr   = sum_reg[pag_pkg::INC_W-1:pag_pkg::SUM_ADDR_LSB];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      incA_reg      <= pag_pkg::INC_RST;
      incB_reg      <= pag_pkg::INC_RST;
      activeSel_reg <= 1'b0;
      pending_reg   <= 1'b0;
      sum_reg       <= pag_pkg::SUM_RST;
    end
    else
    begin
      incA_reg      <= incA_next;
      incB_reg      <= incB_next;
      activeSel_reg <= activeSel_next;
      pending_reg   <= pending_next;
      sum_reg       <= sum_next;
    end
  end

  // Outputs
  assign addrStrobe = addrStrobe_reg;
  assign phaseSum   = sum_reg;

  // Channel slices: own phase word and own RAM [RULE8] [RULE11]
  genvar ch;
  generate
    for (ch = 0; ch < pag_pkg::NUM_CH; ch++)
    begin : g_chan
      assign phaseWrEn[ch] = ctrlWr.phaseWr
                           && (ctrlWr.chan == pag_pkg::CH_W'(ch));
      assign waveWrEn[ch]  = waveWr.wr && (waveWr.chan == pag_pkg::CH_W'(ch));

      pag_chan_phase u_phase
      (
        .clk           (clk),
        .reset_n       (reset_n),
        .tick          (tick),
        .wrEn          (phaseWrEn[ch]),
        .wrData        (ctrlWr.data[pag_pkg::ADDR_W-1:0]),
        .sumAddr       (sumAddr),
        .phaseLive_reg (phaseLive[ch]),
        .chanAddr_reg  (chanAddr[ch])
      );

      // RAM indexed by the top bits of the address [RULE7]
      pag_wave_ram u_ram
      (
        .clk        (clk),
        .wrEn       (waveWrEn[ch]),
        .wrAddr     (waveWr.addr),
        .wrData     (waveWr.data),
        .rdAddr     (chanAddr[ch][pag_pkg::ADDR_W-1:pag_pkg::RAM_IDX_LSB]),
        .rdData_reg (chanSample[ch])
      );
    end
  endgenerate

  // Checks on step timing and accumulation
  step_period_a: assert property ( // [RULE4]
    @(posedge clk) disable iff (!reset_n)
    tick |-> ##20 tick)
    else $error("step period is not 20 clocks");

  step_gap_a: assert property ( // [RULE4]
    @(posedge clk) disable iff (!reset_n)
    tick |=> !tick [*8])
    else $error("step repeated too soon");

  sum_add_a: assert property ( // [RULE2]
    @(posedge clk) disable iff (!reset_n)
    tick |=> sum_reg == pag_pkg::INC_W'($past(sum_reg) + $past(incUsed)))
    else $error("sum did not add the live increment");

  sum_hold_a: assert property ( // [RULE17]
    @(posedge clk) disable iff (!reset_n)
    !tick |=> $stable(sum_reg))
    else $error("sum moved between steps");

  pair_swap_a: assert property ( // [RULE15]
    @(posedge clk) disable iff (!reset_n)
    (tick && pending_reg) |=> activeSel_reg != $past(activeSel_reg))
    else $error("pending word not swapped in");

  pair_keep_a: assert property ( // [RULE9]
    @(posedge clk) disable iff (!reset_n)
    (!tick || !pending_reg) |=> $stable(activeSel_reg))
    else $error("increment pair swapped without a new word");

  live_inc_a: assert property ( // [RULE15]
    @(posedge clk) disable iff (!reset_n)
    !swapNow |=> incActive == $past(incActive))
    else $error("live increment overwritten by a write");

  write_pend_a: assert property ( // [RULE17]
    @(posedge clk) disable iff (!reset_n)
    ctrlWr.freqWr |=> pending_reg ##[0:20] (tick && pending_reg))
    else $error("frequency word never taken at a step");

  strobe_step_a: assert property ( // [RULE3]
    @(posedge clk) disable iff (!reset_n)
    addrStrobe == $past(tick))
    else $error("address strobe not one clock after step");

  chan_addr_a: assert property ( // [RULE12]
    @(posedge clk) disable iff (!reset_n)
    ##1 chanAddr[0] == pag_pkg::ADDR_W'($past(sumAddr) + $past(phaseLive[0])))
    else $error("channel address is not sum plus offset");

  // Checks on step rate, increment pair and channel slices
  tick_count_a: assert property ( // [RULE4]
    @(posedge clk) disable iff (!reset_n)
    tickCnt_reg <= pag_pkg::TICK_LAST)
    else $error("step divider out of range");

  strobe_pulse_a: assert property ( // [RULE4]
    @(posedge clk) disable iff (!reset_n)
    addrStrobe |=> !addrStrobe)
    else $error("address strobe longer than one clock");

  strobe_gap_a: assert property ( // [RULE6]
    @(posedge clk) disable iff (!reset_n)
    addrStrobe |-> ##20 addrStrobe)
    else $error("address rate changed");

  idle_load_a: assert property ( // [RULE1]
    @(posedge clk) disable iff (!reset_n)
    ctrlWr.freqWr |=>
      (activeSel_reg ? incA_reg : incB_reg) == $past(ctrlWr.data))
    else $error("frequency word not in the idle register");

  swap_value_a: assert property ( // [RULE15]
    @(posedge clk) disable iff (!reset_n)
    tick |=> incActive == $past(incUsed))
    else $error("live increment is not the one just added");

  pend_clear_a: assert property ( // [RULE15]
    @(posedge clk) disable iff (!reset_n)
    (tick && !ctrlWr.freqWr) |=> !pending_reg)
    else $error("pending flag kept after its step");

  pend_idle_a: assert property ( // [RULE9]
    @(posedge clk) disable iff (!reset_n)
    (!pending_reg && !ctrlWr.freqWr) |=> !pending_reg)
    else $error("pending flag set without a write");

  sum_wrap_a: assert property ( // [RULE16]
    @(posedge clk) disable iff (!reset_n)
    (tick && (sum_reg > ~incUsed)) |=> sum_reg < $past(sum_reg))
    else $error("sum did not wrap at full width");

  phase_hold_a: assert property ( // [RULE17]
    @(posedge clk) disable iff (!reset_n)
    !tick |=> $stable(phaseLive))
    else $error("phase word went live between steps");

  chan_hold_a: assert property ( // [RULE3]
    @(posedge clk) disable iff (!reset_n)
    !addrStrobe |=> $stable(chanAddr))
    else $error("channel address moved between steps");

  shared_ch1_a: assert property ( // [RULE10]
    @(posedge clk) disable iff (!reset_n)
    !addrStrobe |-> pag_pkg::ADDR_W'(chanAddr[1] - chanAddr[0])
                 == pag_pkg::ADDR_W'(phaseLive[1] - phaseLive[0]))
    else $error("channel 1 does not share the sum");

  shared_ch2_a: assert property ( // [RULE10]
    @(posedge clk) disable iff (!reset_n)
    !addrStrobe |-> pag_pkg::ADDR_W'(chanAddr[2] - chanAddr[0])
                 == pag_pkg::ADDR_W'(phaseLive[2] - phaseLive[0]))
    else $error("channel 2 does not share the sum");

  shared_ch3_a: assert property ( // [RULE10]
    @(posedge clk) disable iff (!reset_n)
    !addrStrobe |-> pag_pkg::ADDR_W'(chanAddr[3] - chanAddr[0])
                 == pag_pkg::ADDR_W'(phaseLive[3] - phaseLive[0]))
    else $error("channel 3 does not share the sum");

  chan_addr1_a: assert property ( // [RULE12]
    @(posedge clk) disable iff (!reset_n)
    ##1 chanAddr[1] == pag_pkg::ADDR_W'($past(sumAddr) + $past(phaseLive[1])))
    else $error("channel 1 address is not sum plus offset");

  chan_addr2_a: assert property ( // [RULE12]
    @(posedge clk) disable iff (!reset_n)
    ##1 chanAddr[2] == pag_pkg::ADDR_W'($past(sumAddr) + $past(phaseLive[2])))
    else $error("channel 2 address is not sum plus offset");

  chan_addr3_a: assert property ( // [RULE12]
    @(posedge clk) disable iff (!reset_n)
    ##1 chanAddr[3] == pag_pkg::ADDR_W'($past(sumAddr) + $past(phaseLive[3])))
    else $error("channel 3 address is not sum plus offset");

  wave_one_a: assert property ( // [RULE8]
    @(posedge clk) disable iff (!reset_n)
    $onehot0(waveWrEn))
    else $error("wave point written to more than one channel");

  wave_sel_a: assert property ( // [RULE8]
    @(posedge clk) disable iff (!reset_n)
    waveWr.wr |-> waveWrEn[waveWr.chan])
    else $error("wave point missed its channel");

  phase_sel_a: assert property ( // [RULE11]
    @(posedge clk) disable iff (!reset_n)
    ctrlWr.phaseWr |-> $onehot(phaseWrEn) && phaseWrEn[ctrlWr.chan])
    else $error("phase word missed its channel");

  phase_none_a: assert property ( // [RULE11]
    @(posedge clk) disable iff (!reset_n)
    !ctrlWr.phaseWr |-> phaseWrEn == '0)
    else $error("phase word written without a request");

endmodule : pag_phase_acc

// [pkg/pag_pkg.sv]
// Purpose: Shared constants and carriers for the phase address generator
// Assumes: One 200 MHz system clock, accumulator stepped at 10 MHz
// Notes:   Widths and counts are fixed; channel count 4 is tied to the 2-bit CH_W
package pag_pkg;

  // Clock and accumulator step rate
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned ACC_RATE_HZ = 10_000_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / ACC_RATE_HZ;
  localparam int unsigned TICK_CW     = $clog2(TICK_CYCLES);
  localparam logic [TICK_CW-1:0] TICK_LAST =
    TICK_CW'(TICK_CYCLES - 1);
  localparam logic [TICK_CW-1:0] TICK_CNT_RST = '0;

  // Datapath widths
  localparam int unsigned INC_W    = 40;
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned WAVE_PTS = 8192;
  localparam int unsigned WAVE_AW  = $clog2(WAVE_PTS);
  localparam int unsigned AMP_W    = 12;
  localparam int unsigned NUM_CH   = 4;
  localparam int unsigned CH_W     = 2;

  // Field positions: address is the top of the sum, RAM index the top
  // of the address
  localparam int unsigned SUM_ADDR_LSB = INC_W - ADDR_W;
  localparam int unsigned RAM_IDX_LSB  = ADDR_W - WAVE_AW;

  // Values after reset
  localparam logic [INC_W-1:0]  INC_RST   = '0;
  localparam logic [INC_W-1:0]  SUM_RST   = '0;
  localparam logic [ADDR_W-1:0] PHASE_RST = '0;
  localparam logic [ADDR_W-1:0] ADDR_RST  = '0;
  localparam logic [AMP_W-1:0]  AMP_RST   = '0;

  // Control write from the phase engine
  typedef struct packed {
    logic              freqWr;
    logic              phaseWr;
    logic [CH_W-1:0]   chan;
    logic [INC_W-1:0]  data;
  } pag_ctrl_wr_t;

  // Waveform point load into one channel RAM
  typedef struct packed {
    logic               wr;
    logic [CH_W-1:0]    chan;
    logic [WAVE_AW-1:0] addr;
    logic [AMP_W-1:0]   data;
  } pag_wave_wr_t;

endpackage : pag_pkg

// [hdl/pag_wave_ram.sv]
// Purpose: One channel waveform store, one period of amplitude points
// Assumes: Single clock, one write and one read port
// Notes:   Read data come out of a register, one cycle after the index
`timescale 1ns/1ps
module pag_wave_ram
(
  input  wire logic                          clk,
  input  wire logic                          wrEn,
  input  wire logic [pag_pkg::WAVE_AW-1:0]   wrAddr,
  input  wire logic [pag_pkg::AMP_W-1:0]     wrData,
  input  wire logic [pag_pkg::WAVE_AW-1:0]   rdAddr,
  output logic      [pag_pkg::AMP_W-1:0]     rdData_reg
);

  logic [pag_pkg::AMP_W-1:0] mem [pag_pkg::WAVE_PTS];

  // Waveform load and registered read [RULE7]
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData_reg <= mem[rdAddr];
  end

endmodule : pag_wave_ram

// [hdl/pag_chan_phase.sv]
// Purpose: Per-channel phase offset and waveform address
// Assumes: Tick marks each accumulator step
// Notes:   Offset is staged and goes live only on a tick
`timescale 1ns/1ps
module pag_chan_phase
(
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         tick,
  input  wire logic                         wrEn,
  input  wire logic [pag_pkg::ADDR_W-1:0]   wrData,
  input  wire logic [pag_pkg::ADDR_W-1:0]   sumAddr,
  output logic      [pag_pkg::ADDR_W-1:0]   phaseLive_reg,
  output logic      [pag_pkg::ADDR_W-1:0]   chanAddr_reg
);

  logic [pag_pkg::ADDR_W-1:0] phaseStage_reg;
  logic [pag_pkg::ADDR_W-1:0] phaseStage_next;
  logic [pag_pkg::ADDR_W-1:0] phaseLive_next;
  logic [pag_pkg::ADDR_W-1:0] chanAddr_next;

  // Staging keeps a mid-step write off the address [RULE17]
  assign phaseStage_next = wrEn ? wrData : phaseStage_reg;
  assign phaseLive_next  = tick ? phaseStage_next : phaseLive_reg; // [RULE11]
  // Offset added to the shared sum, wraps at 16 bits [RULE12] [RULE16]
  assign chanAddr_next   = pag_pkg::ADDR_W'(sumAddr + phaseLive_reg);

  // Phase registers and channel address
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phaseStage_reg <= pag_pkg::PHASE_RST;
      phaseLive_reg  <= pag_pkg::PHASE_RST;
      chanAddr_reg   <= pag_pkg::ADDR_RST;
    end
    else
    begin
      phaseStage_reg <= phaseStage_next;
      phaseLive_reg  <= phaseLive_next;
      chanAddr_reg   <= chanAddr_next;
    end
  end

endmodule : pag_chan_phase

// [dv/pag_engine_model.sv]
// Purpose: Phase engine model that writes the frequency and phase words
// Assumes: Same clock as the accumulator; addrStrobe marks each step
// Notes:   Between writes the data lines carry the inverse of the last word
`timescale 1ns/1ps
module pag_engine_model
(
  input  wire logic                 clk,
  input  wire logic                 addrStrobe,
  output var  pag_pkg::pag_ctrl_wr_t ctrlWr
);
  // Nothing requested at time zero
  initial ctrlWr = '0;

  // One control write, placed in the gap just after a step
  task automatic put
  (
    input logic                      freq,
    input logic                      phase,
    input logic [pag_pkg::CH_W-1:0]  ch,
    input logic [pag_pkg::INC_W-1:0] data
  );
    do @(posedge clk); while (addrStrobe !== 1'b1);
    ctrlWr <= '{freq, phase, ch, data};
    @(posedge clk);
    ctrlWr <= '{1'b0, 1'b0, ~ch, ~data}; // Stale word is not kept
  endtask : put
endmodule : pag_engine_model

// [dv/pag_phase_acc_tb.sv]
// Purpose: Self-checking bench for the phase address generator
// Assumes: Engine model writes once per step gap; bench loads the RAMs
// Notes:   Expectations come from a shadow sum, phase words and RAM copy
`timescale 1ns/1ps
module pag_phase_acc_tb;
  localparam int NC = pag_pkg::NUM_CH;
  logic                               clk;
  logic                               reset_n = 1'b0;
  pag_pkg::pag_ctrl_wr_t              ctrlWr;
  pag_pkg::pag_wave_wr_t              waveWr = '0;
  logic                               addrStrobe;
  logic [pag_pkg::INC_W-1:0]          phaseSum;
  logic [NC-1:0][pag_pkg::ADDR_W-1:0] chanAddr;
  logic [NC-1:0][pag_pkg::AMP_W-1:0]  chanSample;
  logic [pag_pkg::INC_W-1:0]          expSum = '0;
  logic [pag_pkg::INC_W-1:0]          expInc = '0;
  logic [pag_pkg::ADDR_W-1:0]         expPh [NC] = '{default: '0};
  logic [pag_pkg::AMP_W-1:0]          shadow [NC][pag_pkg::WAVE_PTS];
  logic                               sampOk = 1'b0;
  logic                               strobeD = 1'b0;
  logic                               strobeD2 = 1'b0;
  logic                               seen = 1'b0;
  logic [pag_pkg::ADDR_W-1:0]         expA [NC] = '{default: '0};
  int                                 errCount = 0;
  int                                 numChecks = 0;
  int                                 gap = 0;
  localparam int                      CYC_LIMIT = 60000;

  pag_phase_acc u_pag_phase_acc
  (
    .clk        (clk),
    .reset_n    (reset_n),
    .ctrlWr     (ctrlWr),
    .waveWr     (waveWr),
    .addrStrobe (addrStrobe),
    .phaseSum   (phaseSum),
    .chanAddr   (chanAddr),
    .chanSample (chanSample)
  );

  pag_engine_model u_pag_engine_model
  (
    .clk        (clk),
    .addrStrobe (addrStrobe),
    .ctrlWr     (ctrlWr)
  );

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrapUp

  task automatic chk(input string what, input logic [39:0] exp,
                     input logic [39:0] got);
    numChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Channel address: top of the sum plus the channel phase word
  function automatic logic [15:0] expAddr(input logic [39:0] s,
                                          input logic [15:0] ph);
    return s[pag_pkg::INC_W-1 -: pag_pkg::ADDR_W] + ph;
  endfunction : expAddr

  // Watchdog: a hang counts as a mismatch and ends the run
  initial
  begin
    repeat (CYC_LIMIT) @(posedge clk);
    errCount++;
    $display("unexpected cycles expected %0d seen %0d",
             CYC_LIMIT - 1, CYC_LIMIT);
    wrapUp();
  end

  // Step monitor: sum and spacing at the strobe, channel addresses
  // one clock later, samples one clock after that
  always @(posedge clk)
  begin
    if (sampOk && strobeD2)
      for (int c = 0; c < NC; c++)
        chk("chanSample", 40'(shadow[c][expA[c][15:3]]),
            40'(chanSample[c]));
    if (strobeD)
      for (int c = 0; c < NC; c++)
        chk("chanAddr", 40'(expA[c]),
            40'(chanAddr[c]));
    strobeD2 = strobeD;
    strobeD = (addrStrobe === 1'b1);
    if (strobeD)
    begin
      if (seen)
        chk("gap", 40'(pag_pkg::TICK_CYCLES), 40'(gap));
      seen = 1'b1;
      gap = 1;
      expSum = expSum + expInc;
      chk("phaseSum", expSum, phaseSum);
      for (int c = 0; c < NC; c++)
        expA[c] = expAddr(expSum, expPh[c]);
    end
    else
      gap++;
  end

  // One control write through the engine, then the shadow words
  task automatic wr(input logic f, input logic p, input logic [1:0] ch,
                    input logic [39:0] d);
    u_pag_engine_model.put(f, p, ch, d);
    if (f)
      expInc = d;
    if (p)
      expPh[ch] = d[15:0];
  endtask : wr

  task automatic steps(input int n);
    repeat (n) do @(posedge clk); while (addrStrobe !== 1'b1);
  endtask : steps

  // Random points into channels c0..c1, sample checks paused meanwhile
  task automatic load(input int c0, input int c1, input int i0,
                      input int n);
    sampOk <= 1'b0;
    for (int c = c0; c <= c1; c++)
      for (int i = i0; i < i0 + n; i++)
      begin
        @(posedge clk);
        shadow[c][i] = 12'($urandom);
        waveWr <= '{1'b1, 2'(c), 13'(i), shadow[c][i]};
      end
    @(posedge clk);
    waveWr <= '{1'b0, 2'(c0), 13'(~i0), 12'($urandom)};
    repeat (3) @(posedge clk);
    sampOk <= 1'b1;
  endtask : load

  // Main sequence
  initial
  begin
    void'($urandom(32'h9e9c1b0a));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    load(0, NC - 1, 0, pag_pkg::WAVE_PTS);
    $display("test wave fill done");
    wr(1'b1, 1'b0, 2'd0, 40'h00_0123_4567);
    steps(6);
    $display("test fixed frequency done");
    for (int k = 1; k <= 12; k++)
      wr(1'b1, 1'b0, 2'd0, 40'(k) << 30);
    $display("test frequency sweep done");
    for (int c = 0; c < NC; c++)
      wr(1'b0, 1'b1, 2'(c), 40'(16'h4000 * c));
    for (int k = 0; k < 16; k++)
      wr(1'b0, 1'b1, 2'(k),
         40'(expPh[k % NC] + 16'((k % NC + 1) * 97)));
    $display("test phase offset and sweep done");
    wr(1'b1, 1'b0, 2'd0, {40{1'b1}});
    steps(3);
    wr(1'b1, 1'b1, 2'd3, 40'hff_8000_1234);
    steps(2);
    $display("test wrap and joint write done");
    load(1, 1, 100, 300);
    steps(4);
    $display("test single channel reload done");
    for (int k = 0; k < 60; k++)
      wr(1'($urandom), 1'($urandom), 2'($urandom),
         {8'($urandom), 32'($urandom)});
    steps(4);
    $display("test random writes done");
    wrapUp();
  end
endmodule : pag_phase_acc_tb
